// [verilog/adcc_defines.svh]
// Offsets, field positions, reset values and timing counts of the converter control.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// Register byte offsets
`define ADCC_OFF_CTRL0     8'h00
`define ADCC_OFF_CTRL1     8'h04
`define ADCC_OFF_PINSEL    8'h08
`define ADCC_OFF_PULLUP    8'h0c
`define ADCC_OFF_DIR       8'h10
`define ADCC_OFF_IRQ_STAT  8'h14
`define ADCC_OFF_IRQ_MASK  8'h18

// Control zero field positions
`define ADCC_C0_START      7
`define ADCC_C0_BUSY       6
`define ADCC_C0_PWR        5

// Control one field positions
`define ADCC_C1_REF_LSB    3
`define ADCC_C1_CKS_LSB    0

// Reset values
`define ADCC_RST_CTRL      8'h00
`define ADCC_RST_PINSEL    8'h00

// Reference code that picks the supply rail
`define ADCC_REF_SUPPLY    2'h1

// Conversion phases in conversion clock cycles
`define ADCC_SAMPLE_CYC    5'h04
`define ADCC_CONV_CYC      5'h0c
`define ADCC_TOTAL_CYC     5'h10

// Number of analog-capable pins
`define ADCC_NPINS         8

`endif

// [verilog/adcc_pkg.sv]
// Types shared by the converter control design.
// Assumes adcc_defines.svh on the include path.
`include "adcc_defines.svh"
package adcc_pkg;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ADCC_IDLE   = 2'b00,
    ADCC_SAMPLE = 2'b01,
    ADCC_CONV   = 2'b10
  } adcc_state_t;

  // Control to the analog core
  typedef struct packed {
    logic       power_on;
    logic       ref_is_supply;
    logic       sample;
    logic       convert;
    logic       ck_en;
  } adcc_core_t;

  // Per-pin override to the port logic
  typedef struct packed {
    logic [`ADCC_NPINS-1:0] analog;
    logic [`ADCC_NPINS-1:0] pullup_en;
    logic [`ADCC_NPINS-1:0] out_en;
  } adcc_pins_t;

endpackage

// [verilog/adcc_ctrl.sv]
// Successive-approximation converter control with AXI4-Lite register access.
// Assumes one 250 MHz clock, synchronous active-low reset, a same-clock analog core.
//
// Summary of operation
// [R01] Reference code 01 picks supply rail; 00, 10, 11 pick external reference pin.
// [R02] Conversion clock is system clock divided by two to the select value.
// [R03] Start bit written low, high, then low triggers one conversion.
// [R04] Start bit left high never starts a conversion.
// [R05] Busy flag sets once a conversion is started and stays set throughout.
// [R06] Busy flag clears when the conversion ends.
// [R07] Conversion end sets the converter interrupt request flag.
// [R08] Enabled interrupt request drives the interrupt output to the core.
// [R09] Software may poll busy flag instead of using the interrupt.
// [R10] Software keeps conversion clock period between 0.5us and 10us.
// [R11] Converter works only while its power enable bit is high.
// [R12] Software waits a settling delay after power enable before starting.
// [R13] Software should clear power enable when conversions are not needed.
// [R14] Analog pin selection disables all other functions of that pin.
// [R15] Analog pin selection disconnects that pin's pull-high resistor.
// [R16] Analog pin selection overrides port direction control.
// [R17] Software frees the reference pin's other functions when it is used.
// [R18] Conversion lasts 16 conversion clocks: 4 sampling then 12 converting.
// [R19] Start falling edge found in system clock; busy within one conversion clock.
`include "adcc_defines.svh"
module adcc_ctrl (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Analog core and pin control
  output adcc_pkg::adcc_core_t         core_o,
  output adcc_pkg::adcc_pins_t         pins_o,
  // Interrupt to the core
  output logic                         irq_o
);

  logic [7:0]             ctrl0_q, ctrl1_q;
  logic [`ADCC_NPINS-1:0] pinsel_q, pullup_q, dir_q;
  logic                   irq_stat_q, irq_mask_q;
  logic                   busy_q, start_prev_q, trig_q;
  logic [6:0]             div_q;
  logic                   ck_en_q;
  logic [4:0]             cyc_q;
  adcc_pkg::adcc_state_t  state_q;
  logic                   aw_held_q, w_held_q;
  logic [7:0]             awaddr_q;
  logic [31:0]            wdata_q;
  logic                   wr_fire, done;
  logic                   pwr;

  // Mask of the low select bits for the divider
  function automatic logic [6:0] adcc_div_mask(input logic [2:0] sel);
    adcc_div_mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
  endfunction

  // Write-one-to-clear test on the interrupt status
  function automatic logic adcc_w1c(input logic [7:0] a, input logic [31:0] d);
    adcc_w1c = (a == `ADCC_OFF_IRQ_STAT) && d[0];
  endfunction

  assign pwr     = ctrl0_q[`ADCC_C0_PWR];
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // Write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // Write response, unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q > `ADCC_OFF_IRQ_MASK || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register stores on a completed write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q    <= `ADCC_RST_CTRL;
      ctrl1_q    <= `ADCC_RST_CTRL;
      pinsel_q   <= `ADCC_RST_PINSEL;
      pullup_q   <= `ADCC_RST_PINSEL;
      dir_q      <= `ADCC_RST_PINSEL;
      irq_mask_q <= 1'b0;
    end else if (wr_fire) begin
      unique case (awaddr_q)
        `ADCC_OFF_CTRL0:    ctrl0_q    <= wdata_q[7:0];
        `ADCC_OFF_CTRL1:    ctrl1_q    <= wdata_q[7:0];
        `ADCC_OFF_PINSEL:   pinsel_q   <= wdata_q[7:0];
        `ADCC_OFF_PULLUP:   pullup_q   <= wdata_q[7:0];
        `ADCC_OFF_DIR:      dir_q      <= wdata_q[7:0];
        `ADCC_OFF_IRQ_MASK: irq_mask_q <= wdata_q[0];
        default: ;
      endcase
    end
  end

  // Start bit falling edge after a high, in the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_prev_q <= 1'b0;
      trig_q       <= 1'b0;
    end else begin
      start_prev_q <= ctrl0_q[`ADCC_C0_START];
      // Only high-to-low completes the pulse; a held high never fires [R03] [R04] [R19]
      if (start_prev_q && !ctrl0_q[`ADCC_C0_START] && pwr && !busy_q)
        trig_q <= 1'b1;
      else if (busy_q || !pwr)
        trig_q <= 1'b0;
    end
  end

  // Power-of-two divider giving a conversion clock enable
  always_ff @(posedge aclk) begin
    if (!aresetn || !pwr) begin
      div_q   <= 7'h00;
      ck_en_q <= 1'b0;
    end else begin
      div_q   <= ((div_q & adcc_div_mask(ctrl1_q[2:0])) ==
                  adcc_div_mask(ctrl1_q[2:0])) ? 7'h00 : 7'(div_q + 7'h01); // [R02]
      ck_en_q <= (div_q & adcc_div_mask(ctrl1_q[2:0])) == adcc_div_mask(ctrl1_q[2:0]);
    end
  end

  // Conversion sequencer, 4 sampling then 12 converting cycles
  assign done = (state_q == adcc_pkg::ADCC_CONV) && ck_en_q &&
                (cyc_q == `ADCC_TOTAL_CYC - 5'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn || !pwr) begin // [R11]
      state_q <= adcc_pkg::ADCC_IDLE;
      cyc_q   <= 5'h00;
      busy_q  <= 1'b0;
    end else if (ck_en_q) begin
      unique case (state_q)
        adcc_pkg::ADCC_IDLE: if (trig_q) begin
          state_q <= adcc_pkg::ADCC_SAMPLE;
          cyc_q   <= 5'h00;
          busy_q  <= 1'b1; // [R05] [R19]
        end
        adcc_pkg::ADCC_SAMPLE: begin
          cyc_q <= cyc_q + 5'h01;
          if (cyc_q == `ADCC_SAMPLE_CYC - 5'h01)
            state_q <= adcc_pkg::ADCC_CONV; // [R18]
        end
        adcc_pkg::ADCC_CONV: begin
          cyc_q <= cyc_q + 5'h01;
          if (done) begin
            state_q <= adcc_pkg::ADCC_IDLE;
            busy_q  <= 1'b0; // [R06] [R18]
          end
        end
        default: state_q <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  // Sticky completion flag, set beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_stat_q <= 1'b0;
    else if (done)
      irq_stat_q <= 1'b1; // [R07]
    else if (wr_fire && adcc_w1c(awaddr_q, wdata_q))
      irq_stat_q <= 1'b0;
  end

  // Interrupt output and core controls from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_o  <= 1'b0;
      core_o <= '0;
    end else begin
      irq_o                <= (irq_stat_q || done) && irq_mask_q; // [R08]
      core_o.power_on      <= pwr; // [R11]
      core_o.ref_is_supply <= ctrl1_q[4:3] == `ADCC_REF_SUPPLY; // [R01]
      core_o.sample        <= state_q == adcc_pkg::ADCC_SAMPLE;
      core_o.convert       <= state_q == adcc_pkg::ADCC_CONV;
      core_o.ck_en         <= ck_en_q && pwr;
    end
  end

  // Pin overrides: analog wins over pull-high and direction
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pins_o <= '0;
    else begin
      pins_o.analog    <= pinsel_q; // [R14]
      pins_o.pullup_en <= pullup_q & ~pinsel_q; // [R15]
      pins_o.out_en    <= dir_q & ~pinsel_q; // [R16]
    end
  end

  // Read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr)
          `ADCC_OFF_CTRL0:    s_axi_rdata <= {24'h0, ctrl0_q[7], busy_q, ctrl0_q[5:0]}; // [R09]
          `ADCC_OFF_CTRL1:    s_axi_rdata <= {24'h0, ctrl1_q};
          `ADCC_OFF_PINSEL:   s_axi_rdata <= {24'h0, pinsel_q};
          `ADCC_OFF_PULLUP:   s_axi_rdata <= {24'h0, pullup_q};
          `ADCC_OFF_DIR:      s_axi_rdata <= {24'h0, dir_q};
          `ADCC_OFF_IRQ_STAT: s_axi_rdata <= {31'h0, irq_stat_q};
          `ADCC_OFF_IRQ_MASK: s_axi_rdata <= {31'h0, irq_mask_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  property p_ref;
    @(posedge aclk) disable iff (!aresetn)
      core_o.ref_is_supply == ($past(ctrl1_q[4:3]) == 2'h1);
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong"); // [R01]

  property p_held_high;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl0_q[7] && start_prev_q && !busy_q && !trig_q) |=> !trig_q;
  endproperty
  a_held_high: assert property (p_held_high) else $error("start while bit high"); // [R04]

  property p_trigger;
    @(posedge aclk) disable iff (!aresetn)
      (start_prev_q && !ctrl0_q[7] && pwr && !busy_q) |=> trig_q;
  endproperty
  a_trigger: assert property (p_trigger) else $error("falling start missed"); // [R03]

  property p_busy_set;
    @(posedge aclk) disable iff (!aresetn)
      (trig_q && ck_en_q && pwr && state_q == adcc_pkg::ADCC_IDLE) |=> busy_q;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set"); // [R05]

  property p_busy_clr;
    @(posedge aclk) disable iff (!aresetn)
      (done && pwr) |=> !busy_q && irq_stat_q;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("end not flagged"); // [R06]

  property p_len;
    @(posedge aclk) disable iff (!aresetn)
      $rose(state_q == adcc_pkg::ADCC_CONV) |-> $past(cyc_q) == 5'h03;
  endproperty
  a_len: assert property (p_len) else $error("sampling phase length wrong"); // [R18]

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
      (irq_stat_q && irq_mask_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R08]

  property p_power;
    @(posedge aclk) disable iff (!aresetn)
      !pwr |=> !busy_q && state_q == adcc_pkg::ADCC_IDLE;
  endproperty
  a_power: assert property (p_power) else $error("active while off"); // [R11]

  property p_pins;
    @(posedge aclk) disable iff (!aresetn)
      $past(pinsel_q[0]) |-> !pins_o.pullup_en[0] && !pins_o.out_en[0];
  endproperty
  a_pins: assert property (p_pins) else $error("analog pin not isolated"); // [R15]

  property p_busy_hold;
    @(posedge aclk) disable iff (!aresetn)
      (state_q != adcc_pkg::ADCC_IDLE) |-> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early"); // [R05]

  property p_div_full;
    @(posedge aclk) disable iff (!aresetn)
      ($past(aresetn) && $past(pwr) && $past(ctrl1_q[2:0]) == 3'h0) |-> ck_en_q;
  endproperty
  a_div_full: assert property (p_div_full) else $error("no enable at full rate"); // [R02]

  property p_pins_all;
    @(posedge aclk) disable iff (!aresetn)
      ((pins_o.pullup_en | pins_o.out_en) & pins_o.analog) == 8'h00;
  endproperty
  a_pins_all: assert property (p_pins_all) else $error("analog pin still driven"); // [R16]

  c_conv: cover property (@(posedge aclk) disable iff (!aresetn) done);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_o));
  c_slow: cover property (@(posedge aclk) disable iff (!aresetn) busy_q && ctrl1_q[2:0] == 3'h7);

endmodule // adcc_ctrl

// [dv/adcc_core_model.sv]
// Behavioural analog core: counts conversion clocks in each phase.
// Assumes core control from adcc_ctrl on the same clock.
module adcc_core_model (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // Control from the block
  input  wire adcc_pkg::adcc_core_t core,
  // Conversion clocks seen in the last conversion
  output logic [7:0]                smp_q,
  output logic [7:0]                cnv_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic smp_prev_q;

  // Counts restart when a sampling phase opens; nothing runs unpowered
  always_ff @(posedge aclk) begin
    smp_prev_q <= core.sample;
    if (!aresetn) begin
      smp_q <= 8'h00;
      cnv_q <= 8'h00;
    end else if (core.power_on) begin
      if (core.sample && !smp_prev_q) begin
        smp_q <= {7'h00, core.ck_en};
        cnv_q <= 8'h00;
      end else if (core.ck_en && core.sample) begin
        smp_q <= smp_q + 8'h01;
      end else if (core.ck_en && core.convert) begin
        cnv_q <= cnv_q + 8'h01;
      end
    end
  end
endmodule // adcc_core_model

// [dv/tb_adcc_ctrl.sv]
// Self-checking bench for the converter control block.
// Assumes adcc_ctrl and adcc_core_model compiled before it.
`include "adcc_defines.svh"
module tb_adcc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] c1; logic sup; int per;} adcc_row_t;
  logic                 aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq;
  logic [7:0]           awa, ara, smp, cnv;
  logic [31:0]          wd, rd, v;
  logic [1:0]           bresp, rresp, resp;
  adcc_pkg::adcc_core_t core;
  adcc_pkg::adcc_pins_t pins;
  int                   errors, num_checks, cyc, p;
  adcc_row_t            rows[8];

  adcc_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .core_o(core),
    .pins_o(pins), .irq_o(irq));
  adcc_core_model u_core (.aclk(aclk), .aresetn(aresetn), .core(core), .smp_q(smp),
    .cnv_q(cnv));

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write, address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awr === 1'b1) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr === 1'b1) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge aclk);
    resp = bresp;
    br <= 1'b0;
  endtask

  // Register read
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge aclk);
    v = rd;
    resp = rresp;
    rr <= 1'b0;
  endtask

  // Poll busy bit until it reads the wanted level
  task automatic wait_busy(input logic want);
    int n;
    n = 0;
    do begin
      axr(`ADCC_OFF_CTRL0);
      n++;
    end while (v[6] !== want && n < 1024);
  endtask

  // High-then-low start pulse with the given power bit
  task automatic start(input logic [7:0] pwr);
    axw(`ADCC_OFF_CTRL0, {24'h000000, 8'h80 | pwr});
    axw(`ADCC_OFF_CTRL0, {24'h000000, pwr});
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    {awv, wv, br, arv, rr, aresetn} = 6'h00;
    {awa, ara, wd, errors, num_checks, cyc} = '0;
    rows = '{'{8'h00, 0, 1}, '{8'h09, 1, 2}, '{8'h12, 0, 4}, '{8'h1b, 0, 8},
             '{8'h04, 0, 16}, '{8'h0d, 1, 32}, '{8'h16, 0, 64}, '{8'h1f, 0, 128}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk("core", core, 5'h00);
    for (int i = 0; i < 7; i++) begin
      axr(8'(i * 4));
      chk("reset value", v, 32'h00000000);
    end
    axw(`ADCC_OFF_CTRL0, 32'h00000020); // Powered long before any start
    foreach (rows[i]) begin
      axw(`ADCC_OFF_CTRL1, {24'h000000, rows[i].c1});
      repeat (2) do @(posedge aclk); while (core.ck_en !== 1'b1);
      p = 0;
      do begin
        @(posedge aclk);
        p++;
      end while (core.ck_en !== 1'b1);
      chk("ref", core.ref_is_supply, rows[i].sup);
      chk("div", p, rows[i].per);
      axr(`ADCC_OFF_CTRL1);
      chk("ctrl1", v, rows[i].c1);
    end
    axw(`ADCC_OFF_PINSEL, 32'h0000000f); // Reference pin among them
    axw(`ADCC_OFF_PULLUP, 32'h000000ff);
    axw(`ADCC_OFF_DIR, 32'h000000ff);
    repeat (2) @(posedge aclk);
    chk("pins", pins, 24'h0ff0f0);
    // Interrupt enabled conversion, start held high first
    axw(`ADCC_OFF_CTRL1, 32'h00000007); // 128 x 4 ns gives 512 ns period
    axw(`ADCC_OFF_IRQ_MASK, 32'h00000001);
    axw(`ADCC_OFF_CTRL0, 32'h000000a0);
    repeat (40) @(posedge aclk);
    axr(`ADCC_OFF_CTRL0);
    chk("held", v[6], 1'b0);
    axw(`ADCC_OFF_CTRL0, 32'h00000020);
    wait_busy(1'b1);
    chk("busy", v[6], 1'b1);
    chk("irq early", irq, 1'b0);
    wait_busy(1'b0);
    chk("done", v[6], 1'b0);
    chk("irq", irq, 1'b1);
    chk("smp", smp, 8'h04);
    chk("cnv", cnv, 8'h0c);
    axr(`ADCC_OFF_IRQ_STAT);
    chk("stat", v, 32'h00000001);
    axw(`ADCC_OFF_IRQ_STAT, 32'h00000001);
    axr(`ADCC_OFF_IRQ_STAT);
    chk("w1c", v, 32'h00000000);
    chk("irq clr", irq, 1'b0);
    // Masked conversion: flag only
    axw(`ADCC_OFF_IRQ_MASK, 32'h00000000);
    start(8'h20);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk("irq masked", irq, 1'b0);
    axr(`ADCC_OFF_IRQ_STAT);
    chk("stat masked", v, 32'h00000001);
    axw(`ADCC_OFF_IRQ_STAT, 32'h00000001);
    // Power dropped in mid-conversion
    axw(`ADCC_OFF_IRQ_MASK, 32'h00000001);
    start(8'h20);
    wait_busy(1'b1);
    axw(`ADCC_OFF_CTRL0, 32'h00000000); // Power off when not needed
    @(posedge aclk);
    chk("power", core.power_on, 1'b0);
    repeat (80) @(posedge aclk);
    axr(`ADCC_OFF_IRQ_STAT);
    chk("abort stat", v, 32'h00000000);
    chk("abort irq", irq, 1'b0);
    // Start with power off
    start(8'h00);
    repeat (20) @(posedge aclk);
    axr(`ADCC_OFF_CTRL0);
    chk("unpowered", v[6], 1'b0);
    // Unmapped and misaligned places
    axr(8'h1c);
    chk("rresp", resp, 2'h2);
    axw(8'h1c, 32'h00000001);
    chk("bresp", resp, 2'h2);
    axw(8'h02, 32'h00000001);
    chk("bresp mis", resp, 2'h2);
    final_report();
  end
endmodule // tb_adcc_ctrl
